// file: hdl/vta_pkg.sv
// Opcodes and constants of the three-operand vector ALU slice
`default_nettype none
package vta_pkg;
	localparam logic [9:0] OP_DMIN = 10'h282;
	localparam logic [9:0] OP_FMIN3 = 10'h1d0;
	localparam logic [9:0] OP_UMIN3 = 10'h1d2;
	localparam logic [9:0] OP_MQSAD_PK = 10'h1e6;
	localparam logic [9:0] OP_MQSAD_W = 10'h1e7;
	localparam logic [9:0] OP_MSAD = 10'h1e4;
	localparam logic [9:0] OP_QSAD_PK = 10'h1e5;
	localparam logic [9:0] OP_DMUL = 10'h281;
	localparam logic [9:0] OP_SMULHI = 10'h287;
	localparam logic [9:0] OP_UMULHI = 10'h286;
	localparam logic [9:0] OP_UMULLO = 10'h285;
	localparam logic [9:0] OP_PERM = 10'h1ed;
	localparam logic [63:0] DNAN = 64'hfff8_0000_0000_0000;
	localparam logic [31:0] FNAN = 32'h7fc0_0000;
	localparam logic [63:0] DNEG_ZERO = 64'h8000_0000_0000_0000;
	localparam logic [7:0] SEL_ONES = 8'h0d;
	localparam logic [7:0] SEL_ZERO = 8'h0c;
	localparam logic [7:0] SEL_SIGN = 8'h08;
	localparam logic [7:0] BYTE_ONES = 8'hff;
	localparam logic [2:0] NREGS_1 = 3'h1;
	localparam logic [2:0] NREGS_2 = 3'h2;
	localparam logic [2:0] NREGS_4 = 3'h4;
	localparam logic [12:0] DEXP_BIAS = 13'h03ff;
	localparam logic [12:0] DEXP_MAX = 13'h07ff;
	typedef enum logic [2:0] {
		SL_OPEN = 3'b000,
		SL_B1 = 3'b001,
		SL_B2 = 3'b011,
		SL_B3 = 3'b010,
		SL_CO = 3'b110
	} vta_slot_e;
endpackage
`default_nettype wire

// file: hdl/vta_dmul.sv
// Double-precision multiplier with flush-to-zero and special values
`default_nettype none
module vta_dmul (
	input wire logic [63:0] a,
	input wire logic [63:0] b,
	output logic [63:0] y
);
	logic a_nan, b_nan, a_inf, b_inf, a_zd, b_zd, sgn;
	logic [105:0] prod;
	logic [52:0] mant;
	logic [53:0] rnd_m;
	logic grd, stk;
	logic [12:0] ex;

	always_comb begin
		a_nan = (&a[62:52]) && (|a[51:0]);
		b_nan = (&b[62:52]) && (|b[51:0]);
		a_inf = (&a[62:52]) && !(|a[51:0]);
		b_inf = (&b[62:52]) && !(|b[51:0]);
		a_zd = !(|a[62:52]);
		b_zd = !(|b[62:52]);
		sgn = a[63] ^ b[63];
		prod = {1'b1, a[51:0]} * {1'b1, b[51:0]};
		ex = 13'({2'b00, a[62:52]}) + 13'({2'b00, b[62:52]}) -
			vta_pkg::DEXP_BIAS;
		if (prod[105]) begin
			mant = prod[105:53];
			grd = prod[52];
			stk = |prod[51:0];
			ex = ex + 13'h0001;
		end else begin
			mant = prod[104:52];
			grd = prod[51];
			stk = |prod[50:0];
		end
		// Round to nearest even
		rnd_m = {1'b0, mant} + 54'(grd & (stk | mant[0]));
		if (rnd_m[53]) begin
			ex = ex + 13'h0001;
		end
		// NaN first, then inf times zero
		if (a_nan) begin
			y = a | 64'h0008_0000_0000_0000;
		end else if (b_nan) begin
			y = b | 64'h0008_0000_0000_0000;
		end else if ((a_inf && b_zd) || (b_inf && a_zd)) begin
			y = vta_pkg::DNAN;
		end else if (a_inf || b_inf) begin
			y = {sgn, 11'h7ff, 52'h0};
		end else if (a_zd || b_zd || ex[12] || ex == 13'h0000) begin
			y = {sgn, 63'h0};
		end else if (ex >= vta_pkg::DEXP_MAX) begin
			y = {sgn, 11'h7ff, 52'h0};
		end else begin
			y = {sgn, ex[10:0], rnd_m[51:0]};
		end
	end
endmodule // vta_dmul
`default_nettype wire

// file: hdl/vta_alu.sv
// Three-operand vector ALU slice, one lane, one result per cycle except in the three cycles after a multiply issues
`default_nettype none
module vta_alu (
	input wire logic mclk,
	input wire logic nrst,
	input wire logic issue_valid,
	input wire logic [9:0] issue_opcode,
	input wire logic [7:0] issue_dst,
	input wire logic [63:0] src0,
	input wire logic [63:0] src1,
	input wire logic [127:0] src2,
	output logic issue_ready_ff,
	output logic dmul_ready_ff,
	output logic res_valid_ff,
	output logic [7:0] res_dst_ff,
	output logic [2:0] res_nregs_ff,
	output logic [127:0] res_data_ff,
	output logic res_invalid_ff,
	output logic res_unknown_ff
);
	logic rsta_ff, rstb_ff, rst_n;
	logic accept, is_dmul, qmask;
	logic [127:0] nxt_res_data;
	logic [2:0] nxt_res_nregs;
	logic nxt_res_invalid, nxt_res_unknown;
	logic [63:0] dmul_y, dmin_y;
	logic [31:0] fmin_y, umin_y;
	logic f_snan;
	logic [10:0] sad_q [4];
	logic [31:0] perm_y;
	logic signed [63:0] smul;
	logic [63:0] umul;
	vta_pkg::vta_slot_e slot_ff, nxt_slot;

	function automatic logic [63:0] dkey(input logic [63:0] x);
		return x[63] ? ~x : (x | vta_pkg::DNEG_ZERO);
	endfunction

	function automatic logic [32:0] fkey(input logic [31:0] x);
		logic nan;
		nan = (&x[30:23]) && (|x[22:0]);
		return {nan, x[31] ? ~x : (x | 32'h8000_0000)};
	endfunction

	function automatic logic [10:0] sad4(input logic [31:0] a,
		input logic [31:0] b, input logic msk);
		logic [10:0] s;
		logic [7:0] x;
		logic [7:0] r;
		s = 11'h000;
		for (int i = 0; i < 4; i++) begin
			x = a[8*i +: 8];
			r = b[8*i +: 8];
			if (!(msk && r == 8'h00)) begin
				s = s + 11'(x > r ? x - r : r - x);
			end
		end
		return s;
	endfunction

	function automatic logic [7:0] pbyte(input logic [63:0] in,
		input logic [7:0] sel);
		if (sel >= vta_pkg::SEL_ONES) begin
			return vta_pkg::BYTE_ONES;
		end else if (sel == vta_pkg::SEL_ZERO) begin
			return 8'h00;
		// sign replicate of bytes 1, 3, 5, 7
		end else if (sel >= vta_pkg::SEL_SIGN) begin
			return {8{in[8*(2*sel[1:0]+1)+7]}};
		end else begin
			return in[8*sel[2:0] +: 8];
		end
	endfunction

	// Reset release through two flops
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			rsta_ff <= 1'b0;
			rstb_ff <= 1'b0;
		end else begin
			rsta_ff <= 1'b1;
			rstb_ff <= rsta_ff;
		end
	end
	assign rst_n = rstb_ff;

	assign is_dmul = issue_opcode == vta_pkg::OP_DMUL;
	// multiply only from an open slot
	assign accept = issue_valid && issue_ready_ff &&
		(!is_dmul || dmul_ready_ff);

	always_comb begin
		nxt_slot = slot_ff;
		unique case (slot_ff)
			vta_pkg::SL_OPEN: begin
				if (accept && is_dmul) begin
					nxt_slot = vta_pkg::SL_B1;
				end
			end
			vta_pkg::SL_B1: nxt_slot = vta_pkg::SL_B2;
			vta_pkg::SL_B2: nxt_slot = vta_pkg::SL_B3;
			vta_pkg::SL_B3: nxt_slot = vta_pkg::SL_CO;
			vta_pkg::SL_CO: begin
				if (accept) begin
					nxt_slot = vta_pkg::SL_OPEN;
				end
			end
			default: nxt_slot = vta_pkg::SL_OPEN;
		endcase
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			slot_ff <= vta_pkg::SL_OPEN;
			issue_ready_ff <= 1'b0;
			dmul_ready_ff <= 1'b0;
		end else begin
			slot_ff <= nxt_slot;
			issue_ready_ff <= nxt_slot == vta_pkg::SL_OPEN ||
				nxt_slot == vta_pkg::SL_CO;
			dmul_ready_ff <= nxt_slot == vta_pkg::SL_OPEN;
		end
	end

	vta_dmul u_dmul (
		.a(src0),
		.b(src1),
		.y(dmul_y)
	);

	// key order puts negative zero first
	always_comb begin
		if (!(&src0[62:52] && |src0[51:0]) &&
			!(&src1[62:52] && |src1[51:0]) &&
			dkey(src0) < dkey(src1)) begin
			dmin_y = src0;
		end else begin
			dmin_y = src1;
		end
	end

	// NaN sources dropped, quiet NaN only when all are NaN
	always_comb begin
		logic [32:0] k0, k1, k2;
		logic [31:0] m;
		k0 = fkey(src0[31:0]);
		k1 = fkey(src1[31:0]);
		k2 = fkey(src2[31:0]);
		m = src0[31:0];
		if (k1 < k0) begin
			m = src1[31:0];
			k0 = k1;
		end
		if (k2 < k0) begin
			m = src2[31:0];
			k0 = k2;
		end
		fmin_y = k0[32] ? vta_pkg::FNAN : m;
		f_snan = (k1[32] && !src1[22]) || (k2[32] && !src2[22]) ||
			(&src0[30:23] && |src0[22:0] && !src0[22]);
	end

	always_comb begin
		umin_y = src0[31:0];
		if (src1[31:0] < umin_y) begin
			umin_y = src1[31:0];
		end
		if (src2[31:0] < umin_y) begin
			umin_y = src2[31:0];
		end
	end

	// only the plain quad SAD skips the mask
	assign qmask = issue_opcode != vta_pkg::OP_QSAD_PK;
	for (genvar j = 0; j < 4; j++) begin : g_quad
		assign sad_q[j] = sad4(src0[8*j +: 32], src1[31:0], qmask);
		assign perm_y[8*j +: 8] = pbyte({src0[31:0], src1[31:0]},
			src2[8*j +: 8]);
	end

	assign smul = $signed(src0[31:0]) * $signed(src1[31:0]);
	assign umul = src0[31:0] * src1[31:0];

	always_comb begin
		nxt_res_data = 128'h0;
		nxt_res_nregs = vta_pkg::NREGS_1;
		nxt_res_invalid = 1'b0;
		nxt_res_unknown = 1'b0;
		unique case (issue_opcode)
			vta_pkg::OP_DMIN: begin
				nxt_res_data[63:0] = dmin_y;
				nxt_res_nregs = vta_pkg::NREGS_2;
			end
			vta_pkg::OP_DMUL: begin
				nxt_res_data[63:0] = dmul_y;
				nxt_res_nregs = vta_pkg::NREGS_2;
			end
			vta_pkg::OP_FMIN3: begin
				nxt_res_data[31:0] = fmin_y;
				nxt_res_invalid = f_snan;
			end
			vta_pkg::OP_UMIN3: nxt_res_data[31:0] = umin_y;
			vta_pkg::OP_MQSAD_PK, vta_pkg::OP_QSAD_PK: begin
				for (int j = 0; j < 4; j++) begin
					nxt_res_data[16*j +: 16] = src2[16*j +: 16] +
						16'(sad_q[j]);
				end
				nxt_res_nregs = vta_pkg::NREGS_2;
			end
			vta_pkg::OP_MQSAD_W: begin
				for (int j = 0; j < 4; j++) begin
					nxt_res_data[32*j +: 32] = src2[32*j +: 32] +
						32'(sad_q[j]);
				end
				nxt_res_nregs = vta_pkg::NREGS_4;
			end
			// single byte SAD into low word
			vta_pkg::OP_MSAD: begin
				nxt_res_data[31:0] = src2[31:0] + 32'(sad_q[0]);
			end
			vta_pkg::OP_SMULHI: nxt_res_data[31:0] = smul[63:32];
			vta_pkg::OP_UMULHI: nxt_res_data[31:0] = umul[63:32];
			vta_pkg::OP_UMULLO: nxt_res_data[31:0] = umul[31:0];
			vta_pkg::OP_PERM: nxt_res_data[31:0] = perm_y;
			default: nxt_res_unknown = 1'b1;
		endcase
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			res_valid_ff <= 1'b0;
			res_dst_ff <= 8'h00;
			res_nregs_ff <= vta_pkg::NREGS_1;
			res_data_ff <= 128'h0;
			res_invalid_ff <= 1'b0;
			res_unknown_ff <= 1'b0;
		end else begin
			res_valid_ff <= accept;
			if (accept) begin
				res_dst_ff <= issue_dst;
				res_nregs_ff <= nxt_res_nregs;
				res_data_ff <= nxt_res_data;
				res_invalid_ff <= nxt_res_invalid;
				res_unknown_ff <= nxt_res_unknown;
			end
		end
	end

	// Operand copies for the checks below
	logic [63:0] s0_q, s1_q;
	logic [31:0] s2_q;
	logic [9:0] op_q;
	always_ff @(posedge mclk) begin
		if (accept) begin
			s0_q <= src0;
			s1_q <= src1;
			s2_q <= src2[31:0];
			op_q <= issue_opcode;
		end
	end

	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_n);

	dmin_pick_a: assert property (res_valid_ff && op_q == vta_pkg::OP_DMIN
		|-> res_data_ff[63:0] == s0_q || res_data_ff[63:0] == s1_q)
		else $error("double minimum picked neither source");
	dmin_negz_a: assert property (res_valid_ff &&
		op_q == vta_pkg::OP_DMIN && (s0_q | s1_q) == vta_pkg::DNEG_ZERO
		&& (s0_q[62:0] | s1_q[62:0]) == 63'h0
		|-> res_data_ff[63:0] == vta_pkg::DNEG_ZERO)
		else $error("mixed zero minimum not negative");
	pair_dst_a: assert property (accept && is_dmul
		|=> res_valid_ff && res_nregs_ff == vta_pkg::NREGS_2 &&
		res_dst_ff == $past(issue_dst))
		else $error("pair result misplaced");
	umin_three_a: assert property (res_valid_ff &&
		op_q == vta_pkg::OP_UMIN3 |-> res_data_ff[31:0] <= s0_q[31:0] &&
		res_data_ff[31:0] <= s1_q[31:0] && res_data_ff[31:0] <= s2_q)
		else $error("unsigned min too large");
	mulhi_signed_a: assert property (res_valid_ff &&
		op_q == vta_pkg::OP_SMULHI |-> res_data_ff[31:0] ==
		(({{32{s0_q[31]}}, s0_q[31:0]} *
		{{32{s1_q[31]}}, s1_q[31:0]}) >> 32))
		else $error("signed upper product wrong");
	mullo_a: assert property (res_valid_ff &&
		op_q == vta_pkg::OP_UMULLO |->
		res_data_ff[31:0] == 32'(s0_q[31:0] * s1_q[31:0]))
		else $error("lower product wrong");
	perm_ones_a: assert property (res_valid_ff &&
		op_q == vta_pkg::OP_PERM && s2_q[7:0] >= vta_pkg::SEL_ONES
		|-> res_data_ff[7:0] == vta_pkg::BYTE_ONES)
		else $error("permute high selector not ones");
	perm_zero_a: assert property (res_valid_ff &&
		op_q == vta_pkg::OP_PERM && s2_q[7:0] == vta_pkg::SEL_ZERO
		|-> res_data_ff[7:0] == 8'h00)
		else $error("permute selector twelve not zero");
	slot_hold_a: assert property (accept && is_dmul
		|=> !issue_ready_ff [*3] ##1 issue_ready_ff && !dmul_ready_ff)
		else $error("multiply slot sequence broken");
	dmul_nan_a: assert property (res_valid_ff &&
		op_q == vta_pkg::OP_DMUL && &s0_q[62:52] && |s0_q[51:0]
		|-> res_data_ff[63:0] == (s0_q | 64'h0008_0000_0000_0000))
		else $error("multiply NaN not from source 0");

	dmul_issue_c: cover property (accept && is_dmul);
	coissue_c: cover property (accept && slot_ff == vta_pkg::SL_CO);
	perm_sign_c: cover property (accept &&
		issue_opcode == vta_pkg::OP_PERM && src2[7:0] == 8'h0b);
	sad_wide_c: cover property (accept &&
		issue_opcode == vta_pkg::OP_MQSAD_W);
endmodule // vta_alu
`default_nettype wire

// file: testbench/vta_rf_model.sv
// Vector register file model that stores ALU results
`default_nettype none
module vta_rf_model (
	input wire logic mclk,
	input wire logic res_valid,
	input wire logic [7:0] dst,
	input wire logic [2:0] nregs,
	input wire logic [127:0] data
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [31:0] rf [0:255];
	always_ff @(posedge mclk) begin
		if (res_valid) begin
			for (int j = 0; j < 4; j++) begin
				if (j < int'(nregs)) begin
					rf[8'(int'(dst) + j)] <= data[32*j +: 32];
				end
			end
		end
	end
endmodule // vta_rf_model
`default_nettype wire

// file: testbench/vta_alu_tb.sv
// Self-checking bench of the three-operand vector ALU slice
`default_nettype none
module vta_alu_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic mclk, nrst, issue_valid;
	logic [9:0] issue_opcode;
	logic [7:0] issue_dst;
	logic [63:0] src0, src1;
	logic [127:0] src2;
	logic issue_ready_ff, dmul_ready_ff, res_valid_ff;
	logic res_invalid_ff, res_unknown_ff;
	logic [7:0] res_dst_ff;
	logic [2:0] res_nregs_ff;
	logic [127:0] res_data_ff;
	int errors, total_checks;
	logic [63:0] ma [0:4];
	logic [63:0] mb [0:4];
	logic [63:0] my [0:4];
	logic [9:0] iop [0:2];
	logic [31:0] iy [0:2];

	vta_alu vta_alu_inst (.mclk(mclk), .nrst(nrst),
		.issue_valid(issue_valid), .issue_opcode(issue_opcode),
		.issue_dst(issue_dst), .src0(src0), .src1(src1), .src2(src2),
		.issue_ready_ff(issue_ready_ff), .dmul_ready_ff(dmul_ready_ff),
		.res_valid_ff(res_valid_ff), .res_dst_ff(res_dst_ff),
		.res_nregs_ff(res_nregs_ff), .res_data_ff(res_data_ff),
		.res_invalid_ff(res_invalid_ff), .res_unknown_ff(res_unknown_ff));
	vta_rf_model vta_rf_model_inst (.mclk(mclk), .res_valid(res_valid_ff),
		.dst(res_dst_ff), .nregs(res_nregs_ff), .data(res_data_ff));

	task automatic conclude;
		$display("checks %0d errors %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	task automatic chk(input logic [127:0] seen, input logic [127:0] exp);
		total_checks++;
		if (seen !== exp) begin
			errors++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic issue(input logic [9:0] op, input logic [7:0] d,
		input logic [63:0] a, input logic [63:0] b, input logic [127:0] c,
		input logic [2:0] nr, input logic [127:0] exp);
		logic ok;
		logic [127:0] m;
		if (issue_valid !== 1'b1) issue_valid = 1'b1;
		issue_opcode = op;
		issue_dst = d;
		src0 = a;
		src1 = b;
		src2 = c;
		ok = 1'b0;
		for (int i = 0; i < 20 && !ok; i++) begin
			ok = issue_ready_ff === 1'b1 &&
				(op != vta_pkg::OP_DMUL || dmul_ready_ff === 1'b1);
			@(posedge mclk);
			#1;
		end
		if (!ok) begin
			errors++;
			conclude();
		end
		m = nr == 3'h1 ? 128'hffff_ffff :
			nr == 3'h2 ? 128'hffff_ffff_ffff_ffff : '1;
		chk(res_valid_ff, 1'b1);
		chk(res_dst_ff, d);
		chk(res_nregs_ff, nr);
		chk(res_data_ff & m, exp);
	endtask

	task automatic idle;
		issue_valid = 1'b0;
		@(posedge mclk);
		#1;
		chk(res_valid_ff, 1'b0);
	endtask

	task automatic t_dmin;
		logic [63:0] p1, p2, nz;
		p1 = 64'h3ff0_0000_0000_0000;
		p2 = 64'h4000_0000_0000_0000;
		nz = vta_pkg::DNEG_ZERO;
		issue(vta_pkg::OP_DMIN, 8'h10, p1, p2, 0, 3'h2, p1);
		issue(vta_pkg::OP_DMIN, 8'h12, p2, p1, 0, 3'h2, p1);
		issue(vta_pkg::OP_DMIN, 8'h14, nz, 0, 0, 3'h2, nz);
		issue(vta_pkg::OP_DMIN, 8'h16, 0, nz, 0, 3'h2, nz);
		idle();
		chk(vta_rf_model_inst.rf[8'h16], 0);
		chk(vta_rf_model_inst.rf[8'h17], 32'h8000_0000);
	endtask

	task automatic t_min3;
		issue(vta_pkg::OP_FMIN3, 8'h20, 64'h3f80_0000, 64'hc000_0000,
			128'h4040_0000, 3'h1, 128'hc000_0000);
		chk(res_invalid_ff, 1'b0);
		issue(vta_pkg::OP_FMIN3, 8'h21, 64'h7f80_0001, 64'h4040_0000,
			128'h3f80_0000, 3'h1, 128'h3f80_0000);
		chk(res_invalid_ff, 1'b1);
		issue(vta_pkg::OP_UMIN3, 8'h22, 64'h0005, 64'hffff_ffff,
			128'h0003, 3'h1, 128'h0003);
		chk(res_unknown_ff, 1'b0);
		issue(10'h3ff, 8'h23, 64'h0005, 64'h0001, 128'h0002, 3'h1,
			128'h0);
		chk(res_unknown_ff, 1'b1);
		idle();
	endtask

	task automatic t_imul;
		iop[0] = vta_pkg::OP_SMULHI;
		iop[1] = vta_pkg::OP_UMULHI;
		iop[2] = vta_pkg::OP_UMULLO;
		iy[0] = 32'hffff_ffff;
		iy[1] = 32'h0000_0002;
		iy[2] = 32'hffff_fffa;
		for (int k = 0; k < 3; k++) begin
			issue(iop[k], 8'h30, 64'hffff_fffe, 64'h0003, 0, 3'h1,
				iy[k]);
		end
		idle();
	endtask

	task automatic t_perm;
		issue(vta_pkg::OP_PERM, 8'h38, 64'h807f_0102, 64'h8304_0586,
			128'h0d0c_0b03, 3'h1, 128'hff00_ff83);
		issue(vta_pkg::OP_PERM, 8'h39, 64'h807f_0102, 64'h8304_0586,
			128'h0809_0a06, 3'h1, 128'h00ff_007f);
		issue(vta_pkg::OP_PERM, 8'h3a, 64'h807f_0102, 64'h8304_0586,
			128'h2000_040e, 3'h1, 128'hff86_02ff);
		idle();
	endtask

	task automatic t_sad;
		logic [63:0] w;
		w = 64'h0706_0504_0302_0100;
		issue(vta_pkg::OP_MSAD, 8'h40, 64'h1020_3040, 64'h0020_1050,
			128'h0100, 3'h1, 128'h0130);
		issue(vta_pkg::OP_MQSAD_PK, 8'h42, w, 0, 128'h0004_0003_0002_0001,
			3'h2, 128'h0004_0003_0002_0001);
		issue(vta_pkg::OP_QSAD_PK, 8'h44, w, 0, 0, 3'h2,
			128'h0012_000e_000a_0006);
		issue(vta_pkg::OP_MQSAD_W, 8'h48, w, 64'h0100_0000,
			128'h0000_0004_0000_0003_0000_0002_0000_0001, 3'h4,
			128'h0000_0009_0000_0007_0000_0005_0000_0003);
		idle();
		chk(vta_rf_model_inst.rf[8'h4b], 32'h0000_0009);
	endtask

	task automatic t_dmul;
		ma[0] = 64'h3ff0_0000_0000_0000;
		mb[0] = 64'h7ff0_0000_0000_0001;
		my[0] = 64'h7ff8_0000_0000_0001;
		ma[1] = 64'h7ff8_0000_0000_0002;
		mb[1] = 64'h7ff8_0000_0000_0003;
		my[1] = 64'h7ff8_0000_0000_0002;
		ma[2] = 64'h7ff0_0000_0000_0000;
		mb[2] = 0;
		my[2] = vta_pkg::DNAN;
		ma[3] = 64'h7ff0_0000_0000_0000;
		mb[3] = 64'h0000_0000_0000_0001;
		my[3] = vta_pkg::DNAN;
		ma[4] = 64'h8000_0000_0000_0001;
		mb[4] = 64'h3ff0_0000_0000_0000;
		my[4] = vta_pkg::DNEG_ZERO;
		issue(vta_pkg::OP_DMUL, 8'h50, 64'h4000_0000_0000_0000,
			64'h4008_0000_0000_0000, 0, 3'h2,
			128'h4018_0000_0000_0000);
		chk(issue_ready_ff, 1'b0);
		chk(dmul_ready_ff, 1'b0);
		idle();
		chk(issue_ready_ff, 1'b0);
		@(posedge mclk);
		#1;
		chk(issue_ready_ff, 1'b0);
		@(posedge mclk);
		#1;
		chk({issue_ready_ff, dmul_ready_ff}, 2'b10);
		issue(vta_pkg::OP_UMIN3, 8'h60, 64'h0009, 64'h0007, 128'h0008,
			3'h1, 128'h0007);
		chk(dmul_ready_ff, 1'b1);
		for (int k = 0; k < 5; k++) begin
			issue(vta_pkg::OP_DMUL, 8'h52, ma[k], mb[k], 0, 3'h2,
				my[k]);
			issue(vta_pkg::OP_UMIN3, 8'h61, 64'h0003, 64'h0004,
				128'h0005, 3'h1, 128'h0003);
		end
		idle();
		chk(vta_rf_model_inst.rf[8'h53], 32'h8000_0000);
	endtask

	initial begin
		mclk = 1'b0;
		forever #25 mclk = ~mclk;
	end

	initial begin
		nrst = 1'b0;
		issue_valid = 1'b0;
		issue_opcode = '0;
		issue_dst = '0;
		src0 = '0;
		src1 = '0;
		src2 = '0;
		errors = 0;
		total_checks = 0;
		repeat (4) @(posedge mclk);
		#1;
		nrst = 1'b1;
		@(posedge mclk);
		#1;
		t_dmin();
		t_min3();
		t_imul();
		t_perm();
		t_sad();
		t_dmul();
		conclude();
	end
endmodule // vta_alu_tb
`default_nettype wire
